// *** verilog/i2c_dma_setup.v ***
// DMA request generation and slave-transmitter data setup hold for the I2C controller
//
// Implementation choice: strobed register access.
`include "i2c_dma_setup_defs.vh"

module i2c_dma_setup #(
  parameter FIFO_CNT_W = 6
) (
  input wire clk,
  input wire rst,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  output reg [`DATA_W-1:0] rdData,
  input wire controllerEnable,
  input wire [FIFO_CNT_W-1:0] txFifoCount,
  input wire [FIFO_CNT_W-1:0] rxFifoCount,
  input wire i2cClkTick,
  input wire setupStart,
  output reg sclHoldLow,
  output reg setupDone,
  output reg dmaTxReq,
  output reg dmaRxReq,
  output reg [`SETUP_W-1:0] dataSetupCountReg
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam CNT_EXT_W = FIFO_CNT_W + 1;
  localparam [1:0] HOLD_IDLE = 2'b00;
  localparam [1:0] HOLD_BUSY = 2'b01;

  // ----------------------------------------------------------------
  // Registers and next values
  // ----------------------------------------------------------------
  reg [`CTRL_W-1:0] dmaCtrl_r;
  reg [`CTRL_W-1:0] dmaCtrl_nxt;
  reg [`LEVEL_W-1:0] txDmaLevel_r;
  reg [`LEVEL_W-1:0] txDmaLevel_nxt;
  reg [`LEVEL_W-1:0] rxDmaLevel_r;
  reg [`LEVEL_W-1:0] rxDmaLevel_nxt;
  reg [`SETUP_W-1:0] dataSetupCount_nxt;
  reg [`DATA_W-1:0] rdData_nxt;
  reg dmaTxReq_nxt;
  reg dmaRxReq_nxt;
  reg [1:0] holdState_r;
  reg [1:0] holdState_nxt;
  reg [`SETUP_W-1:0] setupCnt_r;
  reg [`SETUP_W-1:0] setupCnt_nxt;
  reg sclHoldLow_nxt;
  reg setupDone_nxt;

  // ----------------------------------------------------------------
  // Decode wires
  // ----------------------------------------------------------------
  wire selCtrl;
  wire selTxLevel;
  wire selRxLevel;
  wire selSetup;
  wire ctrlWrite;
  wire txLevelWrite;
  wire rxLevelWrite;
  wire setupWrite;
  wire txDmaEnable;
  wire rxDmaEnable;
  wire [CNT_EXT_W-1:0] txLevelExt;
  wire [CNT_EXT_W-1:0] rxLevelExt;
  wire [CNT_EXT_W-1:0] txCntExt;
  wire [CNT_EXT_W-1:0] rxCntExt;
  wire holdLastTick;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function [CNT_EXT_W-1:0] extLevel;
    input [`LEVEL_W-1:0] level;
    begin
      extLevel = {{(CNT_EXT_W-`LEVEL_W){1'b0}}, level};
    end
  endfunction

  function [CNT_EXT_W-1:0] extCount;
    input [FIFO_CNT_W-1:0] count;
    begin
      extCount = {1'b0, count};
    end
  endfunction

  function [`DATA_W-1:0] padLevel;
    input [`LEVEL_W-1:0] level;
    begin
      padLevel = {{(`DATA_W-`LEVEL_W){1'b0}}, level};
    end
  endfunction

  function txReqCond;
    input en;
    input [CNT_EXT_W-1:0] count;
    input [CNT_EXT_W-1:0] level;
    begin
      txReqCond = en && (count <= level);
    end
  endfunction

  function rxReqCond;
    input en;
    input [CNT_EXT_W-1:0] count;
    input [CNT_EXT_W-1:0] level;
    begin
      rxReqCond = en && (count > level);
    end
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign selCtrl = hit(addr, `OFF_DMA_REQUEST_CONTROL);
  assign selTxLevel = hit(addr, `OFF_TX_DMA_WATERMARK);
  assign selRxLevel = hit(addr, `OFF_RX_DMA_WATERMARK);
  assign selSetup = hit(addr, `OFF_DATA_LINE_SETUP_DELAY);
  assign ctrlWrite = wrStrobe && selCtrl;
  assign txLevelWrite = wrStrobe && selTxLevel;
  assign rxLevelWrite = wrStrobe && selRxLevel;
  assign setupWrite = wrStrobe && selSetup && !controllerEnable;
  assign txDmaEnable = dmaCtrl_r[`BIT_TX_DMA_ENABLE];
  assign rxDmaEnable = dmaCtrl_r[`BIT_RX_DMA_ENABLE];

  // ----------------------------------------------------------------
  // DMA request control register
  // ----------------------------------------------------------------
  always @* begin
    dmaCtrl_nxt = dmaCtrl_r;
    if (ctrlWrite) begin
      dmaCtrl_nxt = wrData[`CTRL_W-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      dmaCtrl_r <= `RST_DMA_CTRL;
    end else begin
      dmaCtrl_r <= dmaCtrl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Transmit watermark register
  // ----------------------------------------------------------------
  always @* begin
    txDmaLevel_nxt = txDmaLevel_r;
    if (txLevelWrite) begin
      txDmaLevel_nxt = wrData[`LEVEL_W-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      txDmaLevel_r <= `RST_LEVEL;
    end else begin
      txDmaLevel_r <= txDmaLevel_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Receive watermark register
  // ----------------------------------------------------------------
  always @* begin
    rxDmaLevel_nxt = rxDmaLevel_r;
    if (rxLevelWrite) begin
      rxDmaLevel_nxt = wrData[`LEVEL_W-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rxDmaLevel_r <= `RST_LEVEL;
    end else begin
      rxDmaLevel_r <= rxDmaLevel_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Data setup count register
  // ----------------------------------------------------------------
  always @* begin
    dataSetupCount_nxt = dataSetupCountReg;
    if (setupWrite) begin
      dataSetupCount_nxt = wrData[`SETUP_W-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      dataSetupCountReg <= `RST_SETUP;
    end else begin
      dataSetupCountReg <= dataSetupCount_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @* begin
    rdData_nxt = {`DATA_W{1'b0}};
    if (rdStrobe) begin
      if (selCtrl) begin
        rdData_nxt = {{(`DATA_W-`CTRL_W){1'b0}}, dmaCtrl_r};
      end else if (selTxLevel) begin
        rdData_nxt = padLevel(txDmaLevel_r);
      end else if (selRxLevel) begin
        rdData_nxt = padLevel(rxDmaLevel_r);
      end else if (selSetup) begin
        rdData_nxt = {{(`DATA_W-`SETUP_W){1'b0}}, dataSetupCountReg};
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rdData <= {`DATA_W{1'b0}};
    end else begin
      rdData <= rdData_nxt;
    end
  end

  // ----------------------------------------------------------------
  // DMA requests
  // ----------------------------------------------------------------
  assign txLevelExt = extLevel(txDmaLevel_r);
  assign rxLevelExt = extLevel(rxDmaLevel_r);
  assign txCntExt = extCount(txFifoCount);
  assign rxCntExt = extCount(rxFifoCount);

  always @* begin
    dmaTxReq_nxt = txReqCond(txDmaEnable, txCntExt, txLevelExt);
    dmaRxReq_nxt = rxReqCond(rxDmaEnable, rxCntExt, rxLevelExt);
  end

  always @(posedge clk) begin
    if (rst) begin
      dmaTxReq <= 1'b0;
      dmaRxReq <= 1'b0;
    end else begin
      dmaTxReq <= dmaTxReq_nxt;
      dmaRxReq <= dmaRxReq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Setup hold of the clock line
  // ----------------------------------------------------------------
  assign holdLastTick = i2cClkTick && (setupCnt_r <= `SETUP_LAST_TICK);

  always @* begin
    holdState_nxt = holdState_r;
    setupCnt_nxt = setupCnt_r;
    sclHoldLow_nxt = sclHoldLow;
    setupDone_nxt = 1'b0;
    case (holdState_r)
      HOLD_IDLE: begin
        if (setupStart) begin
          holdState_nxt = HOLD_BUSY;
          setupCnt_nxt = dataSetupCountReg;
          sclHoldLow_nxt = 1'b1;
        end
      end
      HOLD_BUSY: begin
        if (holdLastTick) begin
          holdState_nxt = HOLD_IDLE;
          setupCnt_nxt = {`SETUP_W{1'b0}};
          sclHoldLow_nxt = 1'b0;
          setupDone_nxt = 1'b1;
        end else if (i2cClkTick) begin
          setupCnt_nxt = setupCnt_r - `SETUP_STEP;
        end
      end
      default: begin
        holdState_nxt = HOLD_IDLE;
        setupCnt_nxt = {`SETUP_W{1'b0}};
        sclHoldLow_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      holdState_r <= HOLD_IDLE;
      setupCnt_r <= {`SETUP_W{1'b0}};
      sclHoldLow <= 1'b0;
      setupDone <= 1'b0;
    end else begin
      holdState_r <= holdState_nxt;
      setupCnt_r <= setupCnt_nxt;
      sclHoldLow <= sclHoldLow_nxt;
      setupDone <= setupDone_nxt;
    end
  end

endmodule // i2c_dma_setup

// *** verilog/i2c_dma_setup_defs.vh ***
// Register map, field layout and reset values of the DMA request and setup block
`ifndef I2C_DMA_SETUP_DEFS_VH
`define I2C_DMA_SETUP_DEFS_VH
`define ADDR_W 32
`define DATA_W 16
`define OFF_DMA_REQUEST_CONTROL 32'h50001388
`define OFF_TX_DMA_WATERMARK 32'h5000138C
`define OFF_RX_DMA_WATERMARK 32'h50001390
`define OFF_DATA_LINE_SETUP_DELAY 32'h50001394
`define BIT_TX_DMA_ENABLE 1
`define BIT_RX_DMA_ENABLE 0
`define CTRL_W 2
`define LEVEL_W 5
`define SETUP_W 8
`define RST_DMA_CTRL 2'h0
`define RST_LEVEL 5'h00
`define RST_SETUP 8'h64
`define SETUP_MIN 8'h02
`define SETUP_LAST_TICK 8'h01
`define SETUP_STEP 8'h01
`endif

// *** test/i2c_dma_setup_properties.sv ***
// Checker for DMA requests and setup hold
`include "i2c_dma_setup_defs.vh"
module i2c_dma_setup_properties #(parameter FIFO_CNT_W = 6) (
  input wire clk, rst, wrStrobe, controllerEnable, i2cClkTick, setupStart, sclHoldLow, setupDone, dmaTxReq, dmaRxReq,
  input wire [`ADDR_W-1:0] addr, input wire [`DATA_W-1:0] wrData, input wire [FIFO_CNT_W-1:0] txFifoCount, rxFifoCount,
  input wire [`SETUP_W-1:0] dataSetupCountReg);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] ctl_r;
  reg [4:0] txl_r, rxl_r;
  wire setW = wrStrobe && addr == `OFF_DATA_LINE_SETUP_DELAY;
  always @(posedge clk) begin
    if (rst) begin ctl_r <= 2'h0; txl_r <= 5'h00; rxl_r <= 5'h00; end
    else if (wrStrobe) begin
      if (addr == `OFF_DMA_REQUEST_CONTROL) ctl_r <= wrData[1:0];
      if (addr == `OFF_TX_DMA_WATERMARK) txl_r <= wrData[4:0];
      if (addr == `OFF_RX_DMA_WATERMARK) rxl_r <= wrData[4:0];
    end
  end
  reg [7:0] tickCnt_r, loadCnt_r;
  always @(posedge clk) begin
    if (rst) begin tickCnt_r <= 8'h00; loadCnt_r <= 8'h00; end
    else if (setupStart && !sclHoldLow) begin tickCnt_r <= 8'h00; loadCnt_r <= dataSetupCountReg; end
    else if (sclHoldLow && i2cClkTick) tickCnt_r <= tickCnt_r + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_tx_request: assert property (dmaTxReq == $past(ctl_r[1] && txFifoCount <= txl_r))
    else $error("tx request wrong");
  chk_rx_request: assert property (dmaRxReq == $past(ctl_r[0] && rxFifoCount >= rxl_r + 6'h01))
    else $error("rx request wrong");
  chk_dma_off: assert property (ctl_r == 2'h0 |=> !dmaTxReq && !dmaRxReq) else $error("request while off");
  chk_setup_lock: assert property (setW && controllerEnable |=> $stable(dataSetupCountReg))
    else $error("setup written while enabled");
  chk_setup_write: assert property (setW && !controllerEnable |=> dataSetupCountReg == $past(wrData[7:0]))
    else $error("setup write lost");
  chk_hold_start: assert property ($rose(sclHoldLow) |-> $past(setupStart)) else $error("hold without start");
  chk_hold_end: assert property (setupDone |-> !sclHoldLow && $past(sclHoldLow && i2cClkTick))
    else $error("hold end wrong");
  cover property (dmaTxReq);
  cover property (dmaRxReq);
  chk_hold_length: assert property (setupDone |-> tickCnt_r == (loadCnt_r < 8'h02 ? 8'h01 : loadCnt_r))
    else $error("hold length wrong");
  cover property (setupDone);
  cover property (setW && controllerEnable);
endmodule // i2c_dma_setup_properties
bind i2c_dma_setup i2c_dma_setup_properties #(.FIFO_CNT_W(FIFO_CNT_W)) chk (.clk(clk), .rst(rst), .wrStrobe(wrStrobe),
  .controllerEnable(controllerEnable), .i2cClkTick(i2cClkTick), .setupStart(setupStart), .sclHoldLow(sclHoldLow),
  .setupDone(setupDone), .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq), .addr(addr), .wrData(wrData),
  .txFifoCount(txFifoCount), .rxFifoCount(rxFifoCount), .dataSetupCountReg(dataSetupCountReg));

// *** test/dma_partner.sv ***
// DMA controller model filling the transmit and draining the receive FIFO
module dma_partner (input wire clk, rst, ld, dmaTxReq, dmaRxReq, input wire [5:0] txInit, rxInit,
  output reg [5:0] txFifoCount, output reg [5:0] rxFifoCount);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    if (rst || ld) begin txFifoCount <= rst ? 6'h00 : txInit; rxFifoCount <= rst ? 6'h00 : rxInit; end
    else begin
      if (dmaTxReq) txFifoCount <= txFifoCount + 6'h01;
      if (dmaRxReq && rxFifoCount != 6'h00) rxFifoCount <= rxFifoCount - 6'h01;
    end
  end
endmodule // dma_partner

// *** test/i2c_dma_setup_test.sv ***
// Testbench for the DMA request and setup block
`include "i2c_dma_setup_defs.vh"
module i2c_dma_setup_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] CT = `OFF_DMA_REQUEST_CONTROL, TW = `OFF_TX_DMA_WATERMARK, RW = `OFF_RX_DMA_WATERMARK;
  localparam [31:0] SU = `OFF_DATA_LINE_SETUP_DELAY;
  reg clk = 0, rst = 1, wrStrobe = 0, rdStrobe = 0, controllerEnable = 0, i2cClkTick = 0, setupStart = 0, ld = 0, pend = 0;
  reg [31:0] addr = 0;
  reg [15:0] wrData = 0;
  reg [5:0] txInit = 0, rxInit = 0;
  reg [1:0] tc = 0;
  reg [4:0] tl, rl;
  reg [5:0] ti, ri;
  reg [1:0] c;
  wire [15:0] rdData;
  wire [7:0] dataSetupCountReg;
  wire [5:0] txFifoCount, rxFifoCount;
  wire sclHoldLow, setupDone, dmaTxReq, dmaRxReq;
  int mismatches = 0, checked = 0, n = 0, k;
  logic [15:0] expQ[$];
  always #10 clk = ~clk;
  i2c_dma_setup dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .controllerEnable(controllerEnable), .txFifoCount(txFifoCount), .rxFifoCount(rxFifoCount),
    .i2cClkTick(i2cClkTick), .setupStart(setupStart), .sclHoldLow(sclHoldLow), .setupDone(setupDone),
    .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq), .dataSetupCountReg(dataSetupCountReg));
  dma_partner dma (.clk(clk), .rst(rst), .ld(ld), .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq), .txInit(txInit),
    .rxInit(rxInit), .txFifoCount(txFifoCount), .rxFifoCount(rxFifoCount));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin mismatches++; $display("[FAIL] %0t seen %h expected %h", $time, seen, exp); end
  endtask
  task wrap_up;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input [31:0] a, input [15:0] d);
    @(posedge clk) begin addr <= a; wrData <= d; wrStrobe <= 1; end
    @(posedge clk) wrStrobe <= 0;
  endtask
  task rd(input [31:0] a, input [15:0] e);
    @(posedge clk) begin addr <= a; rdStrobe <= 1; expQ.push_back(e); end
    @(posedge clk) rdStrobe <= 0;
  endtask
  always @(posedge clk) begin pend <= rdStrobe; tc <= tc + 2'h1; i2cClkTick <= tc == 2'h3; end
  always @(posedge clk) if (setupStart) n <= 0; else if (sclHoldLow && i2cClkTick) n <= n + 1;
  always @(negedge clk) if (pend) chk(rdData, expQ.pop_front());
  initial begin
    void'($urandom(93));
    repeat (4) @(posedge clk);
    rst <= 0;
    rd(CT, 0); rd(TW, 0); rd(RW, 0); rd(SU, 16'h0064); rd(32'h50001398, 0);
    $display("reset values done");
    for (k = 0; k < 3; k++) begin
      tl = $urandom % 32; rl = $urandom % 32; ti = $urandom; ri = $urandom; c = k + 1;
      wr(TW, tl); wr(RW, rl);
      @(posedge clk) begin txInit <= ti; rxInit <= ri; ld <= 1; end
      @(posedge clk) ld <= 0;
      wr(CT, c); repeat (80) @(posedge clk);
      @(negedge clk);
      chk(dmaTxReq, 0);
      chk(dmaRxReq, 0);
      chk(txFifoCount, (c[1] && ti <= tl) ? tl + 6'h02 : ti);
      chk(rxFifoCount, (c[0] && ri > rl) ? ((rl == 0) ? 0 : rl - 1) : ri);
      rd(CT, c); wr(CT, 0);
    end
    $display("dma requests done");
    controllerEnable <= 1; wr(SU, 16'h000A); rd(SU, 16'h0064);
    // Eleven ticks give an 880 ns hold at the 12.5 MHz tick
    controllerEnable <= 0; wr(SU, 16'h000B); rd(SU, 16'h000B);
    @(posedge clk) setupStart <= 1;
    @(posedge clk) setupStart <= 0;
    for (k = 0; k < 200 && setupDone !== 1'b1; k++) @(negedge clk);
    if (k == 200) mismatches++;
    else begin
      chk(n[15:0], 16'h000B);
      chk(sclHoldLow, 0);
      chk(dataSetupCountReg, 16'h000B);
    end
    $display("setup hold done");
    wrap_up;
  end
endmodule // i2c_dma_setup_test
